//--- rtl/spc_counter.sv
`timescale 1ns/10ps
module spc_counter #(
   parameter bit DECADE       = 1'b0,
   parameter bit DIRECT_CLEAR = 1'b0
) (
   // Clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_rst,
   input  wire logic              i_ce,
   // Control and data
   input  wire spc_pkg::spc_ctrl_t i_ctrl,
   // Counter outputs
   output logic [3:0]             o_count,
   output logic                   o_ripple_carry_out
);
   // Operating mode chosen at an edge
   typedef enum logic [1:0] {
      MODE_HOLD  = 2'b00,
      MODE_COUNT = 2'b01,
      MODE_LOAD  = 2'b10,
      MODE_CLEAR = 2'b11
   } spc_mode_t;

   // Register and its next value
   spc_pkg::spc_state_t state_reg;
   spc_pkg::spc_state_t state_next;

   // Terminal count of the selected option
   logic [3:0]          term;

   // Decoded controls
   logic                clear_n_w;
   logic                clear_sync;
   logic                load_now;
   logic                count_now;
   spc_mode_t           mode;

   // Terminal and wrap detection
   logic                at_term;
   logic                out_of_range;
   logic                wrap;

   // Look-ahead chain, one stage per bit
   logic [spc_pkg::CNT_W:0]   ones_chain;
   logic [spc_pkg::CNT_W-1:0] inc_binary;
   logic [3:0]                inc;

   // Count and carry after this edge
   logic [3:0]          count_after;
   logic                carry_after;

   assign term = DECADE ? spc_pkg::TERM_DECADE : spc_pkg::TERM_BINARY;

   // Controls act at the clock edge, except clear when DIRECT_CLEAR is set
   assign clear_n_w  = i_ctrl.clear_n;
   assign clear_sync = !DIRECT_CLEAR && !clear_n_w;
   assign load_now   = !i_ctrl.load_n;
   assign count_now  = i_ctrl.count_enable_parallel && i_ctrl.count_enable_trickle;

   // Decade also recovers from 10 to 15
   assign at_term      = (state_reg.count == term);
   assign out_of_range = DECADE && (state_reg.count > spc_pkg::TERM_DECADE);
   assign wrap         = at_term || out_of_range;

   // Bit toggles when all lower bits are one
   assign ones_chain[0] = 1'b1;
   generate
      for (genvar b = 0; b < spc_pkg::CNT_W; b++) begin : g_bit
         assign ones_chain[b+1] = ones_chain[b] && state_reg.count[b];
         assign inc_binary[b]   = state_reg.count[b] ^ ones_chain[b];
      end
   endgenerate

   assign inc = wrap ? spc_pkg::CNT_ZERO : inc_binary;

   // Priority: clear, load, count, hold
   always_comb begin
      mode = MODE_HOLD;
      if (clear_sync) begin
         mode = MODE_CLEAR;
      end else if (load_now) begin
         mode = MODE_LOAD;
      end else if (count_now) begin
         mode = MODE_COUNT;
      end
   end

   always_comb begin
      state_next  = state_reg;
      count_after = state_reg.count;
      unique case (mode)
         MODE_CLEAR: begin
            count_after = spc_pkg::CNT_ZERO;
         end
         MODE_LOAD: begin
            count_after = i_ctrl.data;
         end
         MODE_COUNT: begin
            count_after = inc;
         end
         MODE_HOLD: begin
            count_after = state_reg.count;
         end
      endcase
      // Registered carry follows the trickle enable one edge late
      carry_after      = i_ctrl.count_enable_trickle && (count_after == term);
      state_next.count = count_after;
      state_next.carry = carry_after;
   end

   generate
      if (DIRECT_CLEAR) begin : g_direct_clear
         // Clear overrides clock, load and enables at once
         always_ff @(posedge i_clk or posedge i_rst or negedge clear_n_w) begin
            if (i_rst) begin
               state_reg <= '{count: spc_pkg::CNT_RESET, carry: 1'b0};
            end else if (!clear_n_w) begin
               state_reg <= '{count: spc_pkg::CNT_ZERO, carry: 1'b0};
            end else if (i_ce) begin
               state_reg <= state_next;
            end
         end
      end else begin : g_sync_clear
         always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
               state_reg <= '{count: spc_pkg::CNT_RESET, carry: 1'b0};
            end else if (i_ce) begin
               state_reg <= state_next;
            end
         end
      end
   endgenerate

   assign o_count            = state_reg.count;
   assign o_ripple_carry_out = state_reg.carry;
endmodule // spc_counter

//--- rtl/spc_pkg.sv
package spc_pkg;
   localparam int          CNT_W       = 4;
   localparam logic [3:0]  CNT_RESET   = 4'h0;
   localparam logic [3:0]  CNT_ZERO    = 4'h0;
   localparam logic [3:0]  TERM_DECADE = 4'h9;
   localparam logic [3:0]  TERM_BINARY = 4'hF;

   typedef struct packed {
      logic [3:0] count;
      logic       carry;
   } spc_state_t;

   typedef struct packed {
      logic       load_n;
      logic       clear_n;
      logic       count_enable_parallel;
      logic       count_enable_trickle;
      logic [3:0] data;
   } spc_ctrl_t;
endpackage

//--- verif/spc_counter_asserts.sv
`timescale 1ns/10ps
module spc_counter_asserts #(
   parameter bit DECADE       = 1'b0,
   parameter bit DIRECT_CLEAR = 1'b0
) (
   input wire logic               i_clk,
   input wire logic               i_rst,
   input wire logic               i_ce,
   input wire logic               o_ripple_carry_out,
   input wire spc_pkg::spc_ctrl_t i_ctrl,
   input wire logic [3:0]         o_count
);
   localparam logic [3:0] TERM = DECADE ? spc_pkg::TERM_DECADE : spc_pkg::TERM_BINARY;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   property p_clr; i_ce&&!i_ctrl.clear_n|=>o_count==4'h0; endproperty
   a_clr: assert property (p_clr) else $error("clear");
   property p_ld; i_ce&&i_ctrl.clear_n&&!i_ctrl.load_n|=>
      (DIRECT_CLEAR&&!i_ctrl.clear_n)||o_count==$past(i_ctrl.data); endproperty
   a_ld: assert property (p_ld) else $error("load");
   property p_cy; o_ripple_carry_out|->o_count==TERM; endproperty
   a_cy: assert property (p_cy) else $error("carry");
   property p_hold; i_ce&&i_ctrl.clear_n&&i_ctrl.load_n&&
      !(i_ctrl.count_enable_parallel&&i_ctrl.count_enable_trickle)|=>
      (DIRECT_CLEAR&&!i_ctrl.clear_n)||$stable(o_count); endproperty
   a_hold: assert property (p_hold) else $error("hold");
   property p_step; i_ce&&i_ctrl.clear_n&&i_ctrl.load_n&&
      i_ctrl.count_enable_parallel&&i_ctrl.count_enable_trickle|=>
      (DIRECT_CLEAR&&!i_ctrl.clear_n)||o_count==(($past(o_count)==TERM||
      (DECADE&&$past(o_count)>4'h9))?4'h0:$past(o_count)+4'h1); endproperty
   a_step: assert property (p_step) else $error("step");
   property p_trk; o_ripple_carry_out&&$past(i_ce)|->$past(i_ctrl.count_enable_trickle);
   endproperty
   a_trk: assert property (p_trk) else $error("trickle");
   property p_dclr; DIRECT_CLEAR&&!i_ctrl.clear_n|->o_count==4'h0; endproperty
   a_dclr: assert property (p_dclr) else $error("direct clear");
endmodule // spc_counter_asserts
bind spc_counter spc_counter_asserts #(.DECADE(DECADE),.DIRECT_CLEAR(DIRECT_CLEAR)) i_chk (.*);

//--- verif/spc_next_stage.sv
`timescale 1ns/10ps
module spc_next_stage (input wire logic i_clk,i_rst,i_en,output logic [3:0] o_cnt);
   always_ff @(posedge i_clk,posedge i_rst) if (i_rst) o_cnt<=4'h0; else if (i_en) o_cnt<=o_cnt+4'h1;
endmodule // spc_next_stage

//--- verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   logic i_clk=0,i_rst=1,ce=1,r,rd,yb=0,yd=0;
   spc_pkg::spc_ctrl_t c='0;
   logic [3:0] q,qd,e=0,ed=0;
   logic [4:0] x[$],xd[$];
   integer err_count=0,num_checks=0,seed=25390;
   initial forever #2 i_clk=~i_clk;
   spc_counter i_spc_counter (.i_clk,.i_rst,.i_ce(ce),.i_ctrl(c),.o_count(q),
      .o_ripple_carry_out(r));
   spc_counter #(.DECADE(1'b1),.DIRECT_CLEAR(1'b1)) i_spc_counter_dec (.i_clk,.i_rst,
      .i_ce(ce),.i_ctrl(c),.o_count(qd),.o_ripple_carry_out(rd));
   spc_next_stage i_spc_next_stage (.i_clk,.i_rst,.i_en(r),.o_cnt());
   task chk(logic [4:0] s,t); num_checks++;
      if (s!==t) begin err_count++; $display("FAIL %0t out",$time); end endtask
   task final_report; $display("err %0d chk %0d",err_count,num_checks);
      if (err_count==0&&num_checks>0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish; endtask
   always @(posedge i_clk) if (x.size()) begin #1;
      chk({r,q},x.pop_front());
      chk({rd,qd},xd.pop_front());
   end
   initial begin repeat(12) @(negedge i_clk); i_rst=0;
      repeat(2000) begin @(negedge i_clk); c=$random(seed); ce=|($random(seed)&7);
         c.clear_n=|($random(seed)&15); c.load_n=|($random(seed)&7);
         if (ce) begin e=!c[6]?4'h0:!c[7]?c[3:0]:(c[5]&&c[4])?e+4'h1:e;
            yb=c[4]&&e==4'hF; end
         if (!c[6]) begin ed=4'h0; yd=1'b0; end
         else if (ce) begin ed=!c[7]?c[3:0]:(c[5]&&c[4])?((ed>=4'h9)?4'h0:ed+4'h1):ed;
            yd=c[4]&&ed==4'h9; end
         x.push_back({yb,e}); xd.push_back({yd,ed}); end
      @(negedge i_clk); final_report; end
   initial begin #20000; err_count++; final_report; end
endmodule // tb_top
